/* File: ued_pkg.sv */
// Shared constants and carrier types for the endpoint transfer sequencer.
// Assumes one 20 MHz clock and a link engine that decodes bus packets.
package ued_pkg;

  // ************
  // Sizes and positions
  // ************
  localparam int NUM_EP   = 9;   // Endpoints 0..7 plus the iso endpoint 8.
  localparam int ISO_EP   = 8;
  localparam int EP_W     = 4;
  localparam int PTR_W    = 32;
  localparam int CNT_W    = 10;  // Iso transfers reach 1023 bytes.
  localparam int ADDR_W   = 7;
  localparam int SETUP_N  = 8;
  localparam logic [2:0] SETUP_LAST = 3'h7;
  localparam int SETUP_TYPE  = 0;
  localparam int SETUP_CODE  = 1;
  localparam int SETUP_VAL_L = 2;
  localparam logic [7:0] STD_DEVICE_OUT  = 8'h00;
  localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
  localparam int CAUSE_CRC     = 0;
  localparam int CAUSE_SUSPEND = 1;
  localparam int CAUSE_RESUME  = 2;
  localparam int CAUSE_W       = 3;

  // ************
  // Carrier types
  // ************
  typedef enum logic [1:0] {
    TOK_SETUP, TOK_IN, TOK_OUT, TOK_IN_ACK
  } ued_token_kind_type;

  typedef enum logic [1:0] {
    RESP_NONE, RESP_ACK, RESP_NAK, RESP_STALL
  } ued_resp_type;

  typedef struct packed {
    logic               valid;
    ued_token_kind_type kind;
    logic [EP_W-1:0]    ep;
    logic [CNT_W-1:0]   size;
  } ued_token_type;

  typedef struct packed {
    logic [NUM_EP-1:0] start_in_transfer_task;
    logic [NUM_EP-1:0] start_out_transfer_task;
    logic              ctrl_receive_out_task;
    logic              ctrl_status_stage_task;
    logic              ctrl_stall_task;
  } ued_tasks_type;

  typedef struct packed {
    logic              values_latched_event;
    logic [NUM_EP-1:0] in_transfer_end_event;
    logic [NUM_EP-1:0] out_transfer_end_event;
    logic              data_ack_event;
    logic              ctrl_data_done_event;
    logic              ctrl_setup_received_event;
    logic              general_bus_event;
  } ued_events_type;

  typedef logic [SETUP_N-1:0][7:0] ued_setup_type;

endpackage : ued_pkg

/* File: ued_dma_mover.sv */
// Byte mover that walks one buffer over the memory port.
// Assumes the memory answers each request with a one-cycle acknowledge.
`timescale 1ns/1ps
module ued_dma_mover #(
  parameter int PTR_W = ued_pkg::PTR_W,
  parameter int CNT_W = ued_pkg::CNT_W
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             start_in,
  input  wire logic             write_in,
  input  wire logic [PTR_W-1:0] ptr_in,
  input  wire logic [CNT_W-1:0] count_in,
  input  wire logic             mem_ack_in,
  output logic                  mem_req_out,
  output logic                  mem_write_out,
  output logic [PTR_W-1:0]      mem_addr_out,
  output logic                  done_out,
  output logic [CNT_W-1:0]      moved_out
);
  import ued_pkg::*;

  typedef struct packed {
    logic             req;
    logic             wr;
    logic [PTR_W-1:0] addr;
    logic [CNT_W-1:0] left;
    logic [CNT_W-1:0] moved;
    logic             done;
  } ued_mover_type;

  ued_mover_type st;
  ued_mover_type next_st;

  // A zero-length buffer still ends with a done pulse one cycle on.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start_in) begin
      next_st.addr  = ptr_in;
      next_st.left  = count_in;
      next_st.moved = '0;
      next_st.wr    = write_in;
      next_st.req   = (count_in != '0);
      next_st.done  = (count_in == '0);
    end else if (st.req && mem_ack_in) begin
      next_st.addr  = st.addr + PTR_W'(1);
      next_st.left  = st.left - CNT_W'(1);
      next_st.moved = st.moved + CNT_W'(1);
      if (st.left == CNT_W'(1)) begin
        next_st.req  = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mem_req_out   = st.req;
  assign mem_write_out = st.wr;
  assign mem_addr_out  = st.addr;
  assign done_out      = st.done;
  assign moved_out     = st.moved;

endmodule : ued_dma_mover

/* File: ued_dma_ctrl.sv */
// Endpoint transfer sequencer and control endpoint handling.
// Assumes a link engine delivering decoded tokens and setup bytes, and
// software driving tasks as one-cycle pulses on plain ports.
//
// Summary of operation
// - Start task latches pointer and maximum count.
// - IN data offered once memory read ends.
// - Values_latched_event event plus flags after latching.
// - Per-endpoint end event when buffer consumed.
// - Data event and flags per acknowledged transaction.
// - Endpoint zero uses control data done event.
// - Setup bytes held in eight registers.
// - Setup event once setup bytes readable.
// - Amount shows bytes moved last transfer.
// - NAK control tokens until stage prepared.
// - Stall task stalls; new setup overrides.
// - Set address completed here; address exposed.
// - Control read: values_latched_event, IN end, done.
// - Status task, optional shortcut on done.
// - Receive task lets one OUT be acked.
// - Control write: done, values_latched_event, OUT end.
// - NAK further endpoint zero OUT until rearmed.
// - Bus event records its cause.
`timescale 1ns/1ps
module ued_dma_ctrl #(
  parameter int NUM_EP = ued_pkg::NUM_EP,
  parameter int PTR_W  = ued_pkg::PTR_W,
  parameter int CNT_W  = ued_pkg::CNT_W
) (
  input  wire logic                         clk_in,
  input  wire logic                         reset_n_in,
  input  wire ued_pkg::ued_token_type       token_in,
  input  wire logic                         setup_byte_valid_in,
  input  wire logic [7:0]                   setup_byte_in,
  input  wire ued_pkg::ued_tasks_type       tasks_in,
  input  wire logic [NUM_EP-1:0][PTR_W-1:0] in_buffer_pointer_in,
  input  wire logic [NUM_EP-1:0][CNT_W-1:0] in_transfer_max_count_in,
  input  wire logic [NUM_EP-1:0][PTR_W-1:0] out_buffer_pointer_in,
  input  wire logic [NUM_EP-1:0][CNT_W-1:0] out_transfer_max_count_in,
  input  wire logic [NUM_EP-1:0]            out_size_write_in,
  input  wire logic [NUM_EP-1:0]            in_endpoint_enable_mask_in,
  input  wire logic [NUM_EP-1:0]            out_endpoint_enable_mask_in,
  input  wire logic [2*NUM_EP-1:0]          endpoint_halt_control_in,
  input  wire logic                         data_done_status_short_in,
  input  wire logic [2*NUM_EP-1:0]          latched_flags_clear_in,
  input  wire logic [2*NUM_EP-1:0]          data_flags_clear_in,
  input  wire logic [ued_pkg::CAUSE_W-1:0]  cause_set_in,
  input  wire logic [ued_pkg::CAUSE_W-1:0]  cause_clear_in,
  input  wire logic                         mem_ack_in,
  output logic                              mem_req_out,
  output logic                              mem_write_out,
  output logic [PTR_W-1:0]                  mem_addr_out,
  output ued_pkg::ued_resp_type             resp_out,
  output ued_pkg::ued_events_type           events_out,
  output logic [2*NUM_EP-1:0]               latched_endpoint_flags_out,
  output logic [2*NUM_EP-1:0]               data_ack_endpoint_flags_out,
  output logic [NUM_EP-1:0][CNT_W-1:0]      received_out_byte_size_out,
  output logic [NUM_EP-1:0][CNT_W-1:0]      in_amount_out,
  output logic [NUM_EP-1:0][CNT_W-1:0]      out_amount_out,
  output ued_pkg::ued_setup_type            setup_fields_out,
  output logic [ued_pkg::ADDR_W-1:0]        assigned_device_address_out,
  output logic [ued_pkg::CAUSE_W-1:0]       bus_event_cause_out,
  output logic                              busy_out
);
  import ued_pkg::*;

  // ************
  // State
  // ************
  typedef struct packed {
    logic                         busy;
    logic                         go;
    logic                         act_out;
    logic [EP_W-1:0]              act_ep;
    logic [PTR_W-1:0]             act_ptr;
    logic [CNT_W-1:0]             act_cnt;
    logic [NUM_EP-1:0]            in_ready;
    logic [NUM_EP-1:0]            out_armed;
    logic [NUM_EP-1:0]            out_full;
    logic [NUM_EP-1:0][CNT_W-1:0] rx_size;
    logic [NUM_EP-1:0][CNT_W-1:0] amt_in;
    logic [NUM_EP-1:0][CNT_W-1:0] amt_out;
    ued_setup_type                setup;
    logic [2:0]                   setup_idx;
    logic                         setup_busy;
    logic                         ctrl_stall;
    logic                         status_armed;
    logic                         addr_pending;
    logic [ADDR_W-1:0]            address;
    logic [2*NUM_EP-1:0]          latched_flags;
    logic [2*NUM_EP-1:0]          data_flags;
    logic [CAUSE_W-1:0]           cause;
    ued_events_type               ev;
    ued_resp_type                 resp;
  } ued_state_type;

  ued_state_type   st;
  ued_state_type   next_st;
  logic            mover_done;
  logic [CNT_W-1:0] mover_moved;

  // ************
  // Memory mover
  // ************
  // Only addresses and counts are sequenced; data stays in the buffer.
  ued_dma_mover #(
    .PTR_W (PTR_W),
    .CNT_W (CNT_W)
  ) u_mover (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .start_in      (st.go),
    .write_in      (st.act_out),
    .ptr_in        (st.act_ptr),
    .count_in      (st.act_cnt),
    .mem_ack_in    (mem_ack_in),
    .mem_req_out   (mem_req_out),
    .mem_write_out (mem_write_out),
    .mem_addr_out  (mem_addr_out),
    .done_out      (mover_done),
    .moved_out     (mover_moved)
  );

  // ************
  // Next-state logic
  // ************
  // Hardware sets follow the clears, so an event never loses to a clear.
  always_comb begin
    int                 e;
    logic               found;
    logic [EP_W-1:0]    te;
    logic               ep_ok;
    logic               ctl;
    logic [2*NUM_EP-1:0] lset;
    logic [2*NUM_EP-1:0] dset;
    next_st = st;
    e = 0;
    found = 1'b0;
    te = token_in.ep;
    ep_ok = (token_in.ep < EP_W'(NUM_EP));
    ctl = (token_in.ep == '0);
    lset = '0;
    dset = '0;
    next_st.ev = '0;
    next_st.go = 1'b0;
    next_st.resp = RESP_NONE;

    // Bus cause bits stick until cleared; set beats clear.
    next_st.cause = (st.cause & ~cause_clear_in) | cause_set_in;
    next_st.ev.general_bus_event = |cause_set_in;

    // Starts are refused while a transfer runs; software must wait
    // for the end event, so a refused start is simply dropped.
    if (!st.busy) begin
      for (e = 0; e < NUM_EP; e++) begin
        if (!found && tasks_in.start_in_transfer_task[e]) begin
          found = 1'b1;
          next_st.act_out = 1'b0;
          next_st.act_ep  = EP_W'(e);
          next_st.act_ptr = in_buffer_pointer_in[e];
          next_st.act_cnt = in_transfer_max_count_in[e];
          lset[e] = 1'b1;
        end else if (!found && tasks_in.start_out_transfer_task[e]) begin
          found = 1'b1;
          next_st.act_out = 1'b1;
          next_st.act_ep  = EP_W'(e);
          next_st.act_ptr = out_buffer_pointer_in[e];
          // Never write more than the host actually sent.
          next_st.act_cnt = (out_transfer_max_count_in[e] < st.rx_size[e])
                          ? out_transfer_max_count_in[e]
                          : st.rx_size[e];
          lset[NUM_EP+e] = 1'b1;
        end
      end
      if (found) begin
        next_st.busy = 1'b1;
        next_st.go   = 1'b1;
        next_st.ev.values_latched_event = 1'b1;
      end
    end

    // Transfer end: report the amount and release the buffer.
    if (mover_done) begin
      next_st.busy = 1'b0;
      if (!st.act_out) begin
        next_st.amt_in[st.act_ep] = mover_moved;
        next_st.in_ready[st.act_ep] = 1'b1;
        next_st.ev.in_transfer_end_event[st.act_ep] = 1'b1;
      end else begin
        next_st.amt_out[st.act_ep] = mover_moved;
        next_st.out_full[st.act_ep] = 1'b0;
        next_st.ev.out_transfer_end_event[st.act_ep] = 1'b1;
        // Data endpoints reopen on their own; endpoint zero waits.
        if (st.act_ep != '0) begin
          next_st.out_armed[st.act_ep] = 1'b1;
        end
      end
    end

    // Software permission for the next OUT transaction.
    for (e = 0; e < NUM_EP; e++) begin
      if (out_size_write_in[e]) begin
        next_st.out_armed[e] = 1'b1;
        next_st.out_full[e]  = 1'b0;
      end
    end

    // Control endpoint tasks.
    if (tasks_in.ctrl_receive_out_task) begin
      next_st.out_armed[0] = 1'b1;
    end
    if (tasks_in.ctrl_status_stage_task) begin
      next_st.status_armed = 1'b1;
    end
    if (tasks_in.ctrl_stall_task) begin
      next_st.ctrl_stall = 1'b1;
    end

    // Setup byte capture; the event fires with the last byte stored.
    if (setup_byte_valid_in && st.setup_busy) begin
      next_st.setup[st.setup_idx] = setup_byte_in;
      next_st.setup_idx = st.setup_idx + 3'h1;
      if (st.setup_idx == SETUP_LAST) begin
        next_st.setup_busy = 1'b0;
        next_st.ev.ctrl_setup_received_event = 1'b1;
        if (st.setup[SETUP_TYPE] == STD_DEVICE_OUT &&
            st.setup[SETUP_CODE] == REQ_SET_ADDRESS) begin
          next_st.addr_pending = 1'b1;
        end
      end
    end

    // Token handling.
    if (token_in.valid && ep_ok) begin
      unique case (token_in.kind)
        TOK_SETUP: begin
          if (ctl) begin
            // A new setup overrides stall and drops any prepared stage.
            next_st.ctrl_stall   = 1'b0;
            next_st.in_ready[0]  = 1'b0;
            next_st.out_armed[0] = 1'b0;
            next_st.status_armed = 1'b0;
            next_st.addr_pending = 1'b0;
            next_st.setup_busy   = 1'b1;
            next_st.setup_idx    = '0;
            next_st.resp         = RESP_ACK;
          end
        end
        TOK_IN: begin
          if (!in_endpoint_enable_mask_in[te]) begin
            next_st.resp = RESP_NONE;
          end else if ((ctl && st.ctrl_stall) ||
                       (!ctl && endpoint_halt_control_in[te])) begin
            next_st.resp = RESP_STALL;
          end else if (st.in_ready[te] ||
                       (ctl && (st.status_armed || st.addr_pending))) begin
            next_st.resp = RESP_ACK;
          end else begin
            next_st.resp = RESP_NAK;
          end
        end
        TOK_IN_ACK: begin
          if (ctl && st.in_ready[0]) begin
            next_st.in_ready[0] = 1'b0;
            next_st.ev.ctrl_data_done_event = 1'b1;
            if (data_done_status_short_in) begin
              next_st.status_armed = 1'b1;
            end
          end else if (ctl && (st.status_armed || st.addr_pending)) begin
            // Status stage done; a pending address takes effect now.
            next_st.status_armed = 1'b0;
            if (st.addr_pending) begin
              next_st.addr_pending = 1'b0;
              next_st.address = st.setup[SETUP_VAL_L][ADDR_W-1:0];
            end
          end else if (!ctl && st.in_ready[te]) begin
            next_st.in_ready[te] = 1'b0;
            next_st.ev.data_ack_event = 1'b1;
            dset[te] = 1'b1;
          end
        end
        TOK_OUT: begin
          if (!out_endpoint_enable_mask_in[te]) begin
            next_st.resp = RESP_NONE;
          end else if ((ctl && st.ctrl_stall) ||
                       (!ctl && endpoint_halt_control_in[NUM_EP+te])) begin
            next_st.resp = RESP_STALL;
          end else if (ctl && st.status_armed) begin
            next_st.status_armed = 1'b0;
            next_st.resp = RESP_ACK;
          end else if (st.out_armed[te] && !st.out_full[te]) begin
            next_st.out_armed[te] = 1'b0;
            next_st.out_full[te]  = 1'b1;
            next_st.rx_size[te]   = token_in.size;
            next_st.resp = RESP_ACK;
            if (ctl) begin
              next_st.ev.ctrl_data_done_event = 1'b1;
              if (data_done_status_short_in) begin
                next_st.status_armed = 1'b1;
              end
            end else begin
              next_st.ev.data_ack_event = 1'b1;
              dset[NUM_EP+te] = 1'b1;
            end
          end else begin
            next_st.resp = RESP_NAK;
          end
        end
      endcase
    end

    // Sticky flag registers, set winning over clear.
    next_st.latched_flags = (st.latched_flags & ~latched_flags_clear_in)
                          | lset;
    next_st.data_flags = (st.data_flags & ~data_flags_clear_in)
                       | dset;
  end

  // ************
  // State register
  // ************
  // All-zero reset: idle, nothing armed, address zero.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ************
  // Outputs
  // ************
  // Every output below is a field of the state register.
  assign resp_out                    = st.resp;
  assign events_out                  = st.ev;
  assign latched_endpoint_flags_out  = st.latched_flags;
  assign data_ack_endpoint_flags_out = st.data_flags;
  assign received_out_byte_size_out  = st.rx_size;
  assign in_amount_out               = st.amt_in;
  assign out_amount_out              = st.amt_out;
  assign setup_fields_out            = st.setup;
  assign assigned_device_address_out = st.address;
  assign bus_event_cause_out         = st.cause;
  assign busy_out                    = st.busy;

endmodule : ued_dma_ctrl

/* File: ued_dma_ctrl_assertions.sv */
// Port checker for the endpoint transfer sequencer.
// Assumes it is bound into ued_dma_ctrl; one clock, low reset.
`timescale 1ns/1ps
module ued_dma_ctrl_chk
  import ued_pkg::*;
#(
  parameter int NUM_EP = 9
) (
  input wire logic                  clk_in,
  input wire logic                  reset_n_in,
  input wire ued_token_type         token_in,
  input wire logic                  setup_byte_valid_in,
  input wire logic [7:0]            setup_byte_in,
  input wire ued_tasks_type         tasks_in,
  input wire logic [NUM_EP-1:0]     in_endpoint_enable_mask_in,
  input wire logic [NUM_EP-1:0]     out_endpoint_enable_mask_in,
  input wire logic [CAUSE_W-1:0]    cause_set_in,
  input wire ued_resp_type          resp_out,
  input wire ued_events_type        events_out,
  input wire ued_setup_type         setup_fields_out,
  input wire logic [CAUSE_W-1:0]    bus_event_cause_out,
  input wire logic                  busy_out
);
  // ************
  // Port relations
  // ************
  // All relations share one clock; reset silences them all.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_resp_quiet: assert property (
    !token_in.valid || token_in.ep > 8 |=> resp_out == RESP_NONE)
    else $error("resp without token");
  a_ack_event: assert property (
    resp_out == RESP_ACK && $past(token_in.kind) == TOK_OUT &&
    $past(token_in.ep) != 0 |-> events_out.data_ack_event)
    else $error("OUT ack, no event");
  a_ep0_event: assert property (
    $past(token_in.valid) && $past(token_in.ep) == 0
    |-> !events_out.data_ack_event)
    else $error("data event on ep0");
  a_setup_bytes: assert property (
    events_out.ctrl_setup_received_event
    |-> setup_fields_out[SETUP_LAST] == $past(setup_byte_in))
    else $error("last setup byte lost");
  a_setup_event: assert property (
    events_out.ctrl_setup_received_event |-> $past(setup_byte_valid_in))
    else $error("setup event early");
  a_setup_ack: assert property (
    token_in.valid && token_in.kind == TOK_SETUP && token_in.ep == 0
    |=> resp_out == RESP_ACK)
    else $error("setup not acked");
  a_setup_nak: assert property (
    token_in.valid && token_in.kind == TOK_SETUP && token_in.ep == 0
    ##1 token_in.valid && token_in.kind == TOK_IN && token_in.ep == 0
    && in_endpoint_enable_mask_in[0] && tasks_in == '0
    |=> resp_out == RESP_NAK)
    else $error("IN after setup taken");
  a_start_latch: assert property (
    $rose(busy_out) |-> events_out.values_latched_event &&
    ($past(tasks_in) >> 3) != 0)
    else $error("busy without a start");
  a_latch_idle: assert property (
    events_out.values_latched_event |-> busy_out && !$past(busy_out))
    else $error("values_latched_event event while busy");
  a_end_free: assert property (
    |{events_out.in_transfer_end_event, events_out.out_transfer_end_event}
    |-> !busy_out && $past(busy_out))
    else $error("end without release");
  a_cause_set: assert property (
    cause_set_in != 0 |=>
    (bus_event_cause_out & $past(cause_set_in)) == $past(cause_set_in) &&
    events_out.general_bus_event)
    else $error("cause not recorded");
endmodule : ued_dma_ctrl_chk

bind ued_dma_ctrl ued_dma_ctrl_chk #(.NUM_EP(NUM_EP)) chk_u (
  .clk_in, .reset_n_in, .token_in, .setup_byte_valid_in, .setup_byte_in,
  .tasks_in, .in_endpoint_enable_mask_in, .out_endpoint_enable_mask_in,
  .cause_set_in, .resp_out, .events_out, .setup_fields_out,
  .bus_event_cause_out, .busy_out);

/* File: ued_host_model.sv */
// Far-side model: the bus host replaying tokens and the memory port.
// Assumes the bench drives requests just after rising edges.
`timescale 1ns/1ps
module ued_host_model
  import ued_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          reset_n_in,
  input  wire ued_token_type req_in,
  input  wire logic          stall_in,
  input  wire logic          mem_req_in,
  output ued_token_type      token_out,
  output logic               mem_ack_out
);
  // Tokens leave a cycle after request; memory stalls at random and
  // never acks two bytes back to back, so the mover must hold its request.
  always_ff @(posedge clk_in) begin
    token_out   <= reset_n_in ? req_in : '0;
    mem_ack_out <= reset_n_in && mem_req_in && !mem_ack_out && !stall_in;
  end
endmodule : ued_host_model

/* File: testbench.sv */
// Bench for the endpoint transfer sequencer: transfers, control stages
// and causes. Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
  import ued_pkg::*;
  logic                         clk_in = 1'b0;
  logic                         reset_n_in = 1'b0;
  ued_token_type                req = '0, token;
  ued_tasks_type                tasks = '0;
  logic [NUM_EP-1:0][PTR_W-1:0] inptr = '0;
  logic [NUM_EP-1:0][CNT_W-1:0] incnt = '0, inamt, outamt;
  logic [NUM_EP-1:0]            szw = '0, en = 9'h1df;
  logic [2*NUM_EP-1:0]          lflags, dflags;
  logic [CAUSE_W-1:0]           cset = '0, cclr = '0, cause;
  logic [7:0]                   sb = '0;
  logic [PTR_W-1:0]             addr;
  logic [ADDR_W-1:0]            dev_addr;
  logic                         sb_v = 1'b0, stall = 1'b0, mreq, mwr, mack;
  logic                         busy, sc = 1'b0;
  ued_resp_type                 resp;
  ued_events_type               ev, tev;
  ued_setup_type                sfields;
  ued_resp_type                 expq[$];
  int                           seed = 27, n_errors = 0, check_count = 0;
  int                           c;
  // ************
  // Clock, far side and device
  // ************
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in) stall <= ^$random(seed);
  ued_host_model host_u (.clk_in, .reset_n_in, .req_in(req),
    .stall_in(stall), .mem_req_in(mreq), .token_out(token),
    .mem_ack_out(mack));
  ued_dma_ctrl dut_u (.clk_in, .reset_n_in, .token_in(token),
    .setup_byte_valid_in(sb_v), .setup_byte_in(sb), .tasks_in(tasks),
    .in_buffer_pointer_in(inptr), .in_transfer_max_count_in(incnt),
    .out_buffer_pointer_in(inptr), .out_transfer_max_count_in(incnt),
    .out_size_write_in(szw), .in_endpoint_enable_mask_in(en),
    .out_endpoint_enable_mask_in(en), .endpoint_halt_control_in(18'h0),
    .data_done_status_short_in(sc), .latched_flags_clear_in(18'h0),
    .data_flags_clear_in(18'h0), .cause_set_in(cset),
    .cause_clear_in(cclr), .mem_ack_in(mack), .mem_req_out(mreq),
    .mem_write_out(mwr), .mem_addr_out(addr), .resp_out(resp),
    .events_out(ev), .latched_endpoint_flags_out(lflags),
    .data_ack_endpoint_flags_out(dflags), .received_out_byte_size_out(),
    .in_amount_out(inamt), .out_amount_out(outamt),
    .setup_fields_out(sfields), .assigned_device_address_out(dev_addr),
    .bus_event_cause_out(cause), .busy_out(busy));
  // Every handshake seen is matched against the oldest expected answer.
  always @(negedge clk_in) begin
    if (resp !== RESP_NONE) begin
      if (expq.size() == 0) chk("resp extra", resp, RESP_NONE);
      else chk("resp", resp, expq.pop_front());
    end
  end
  // ************
  // Tasks
  // ************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // Bounded wait on one bit of the packed event vector.
  task automatic wait_ev(input int b);
    int i;
    for (i = 0; i < 300 && ev[b] !== 1'b1; i++) @(negedge clk_in);
    if (i == 300) begin
      chk("event wait", b, 32'hffff);
      results();
    end
  endtask : wait_ev
  task automatic kick(input logic [20:0] t);
    tasks <= t;
    @(posedge clk_in);
    tasks <= '0;
  endtask : kick
  // Three edges: the host replays the token, then its answer settles.
  task automatic tok(input ued_token_kind_type k, input int e, sz,
                     input ued_resp_type r);
    req <= '{1'b1, k, e[EP_W-1:0], sz[CNT_W-1:0]};
    if (r != RESP_NONE) expq.push_back(r);
    @(posedge clk_in);
    req <= '0;
    @(posedge clk_in);
    @(negedge clk_in);
    tev = ev;
    @(posedge clk_in);
  endtask : tok
  task automatic xfer(input bit out, input int e, cnt, exp);
    logic [31:0] p;
    p = $random(seed);
    inptr[e] <= p;
    incnt[e] <= cnt[CNT_W-1:0];
    @(posedge clk_in);
    kick(21'h1 << (out ? 3 + e : 12 + e));
    wait_ev(22);
    chk("latched flag", lflags[out ? 9 + e : e], 1'b1);
    @(negedge clk_in);
    chk("first addr", addr, p);
    chk("direction", mwr, out);
    wait_ev(out ? 4 + e : 13 + e);
    chk("amount", out ? outamt[e] : inamt[e], exp);
    @(posedge clk_in);
  endtask : xfer
  task automatic setup(input logic [63:0] b);
    req <= '{1'b1, TOK_SETUP, 4'h0, 10'h0};
    expq.push_back(RESP_ACK);
    @(posedge clk_in);
    tok(TOK_IN, 0, 0, RESP_NAK);
    for (int i = 0; i < 8; i++) begin
      sb_v <= 1'b1;
      sb <= b[8*i +: 8];
      @(posedge clk_in);
    end
    sb_v <= 1'b0;
    wait_ev(1);
    for (int i = 0; i < 8; i++) chk("setup", sfields[i], b[8*i +: 8]);
    @(posedge clk_in);
  endtask : setup
  // ************
  // Main sequence
  // ************
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    // Random-length IN transfers; data is offered only after each end.
    for (int e = 1; e < 4; e++) begin
      c = ($random(seed) & 15) + 1;
      tok(TOK_IN, e, 0, RESP_NAK);
      xfer(0, e, c, c);
      tok(TOK_IN, e, 0, RESP_ACK);
      tok(TOK_IN_ACK, e, 0, RESP_NONE);
      chk("in flag", dflags[e], 1'b1);
    end
    tok(TOK_IN, 5, 0, RESP_NONE);
    // OUT endpoint two: refused until armed, once per arming.
    tok(TOK_OUT, 2, 4, RESP_NAK);
    szw[2] <= 1'b1;
    @(posedge clk_in);
    szw <= '0;
    tok(TOK_OUT, 2, 4, RESP_ACK);
    chk("out flag", dflags[11], 1'b1);
    tok(TOK_OUT, 2, 4, RESP_NAK);
    xfer(1, 2, 8, 4);
    tok(TOK_OUT, 2, 4, RESP_ACK);
    // Control read with a data stage.
    setup(64'h0040_0000_0100_0680);
    tok(TOK_IN, 0, 0, RESP_NAK);
    tok(TOK_OUT, 0, 2, RESP_NAK);
    xfer(0, 0, 2, 2);
    tok(TOK_IN, 0, 0, RESP_ACK);
    sc <= 1'b1;
    tok(TOK_IN_ACK, 0, 0, RESP_NONE);
    chk("data done", tev[2], 1'b1);
    tok(TOK_IN, 0, 0, RESP_ACK);
    sc <= 1'b0;
    // A stall is overridden by the next setup, here a set address.
    kick(21'h1);
    tok(TOK_IN, 0, 0, RESP_STALL);
    setup(64'h0000_0000_002a_0500);
    tok(TOK_IN, 0, 0, RESP_ACK);
    tok(TOK_IN_ACK, 0, 0, RESP_NONE);
    chk("address", dev_addr, 7'h2a);
    // Control write: one OUT per receive task, then the transfer.
    setup(64'h0002_0000_0000_0140);
    kick(21'h4);
    tok(TOK_OUT, 0, 2, RESP_ACK);
    chk("data done", tev[2], 1'b1);
    tok(TOK_OUT, 0, 2, RESP_NAK);
    xfer(1, 0, 2, 2);
    cset <= 3'h1;
    @(posedge clk_in);
    cset <= '0;
    repeat (2) @(posedge clk_in);
    chk("cause", cause, 3'h1);
    cclr <= 3'h1;
    @(posedge clk_in);
    cclr <= '0;
    repeat (2) @(posedge clk_in);
    chk("cause clear", cause, 3'h0);
    chk("pending", expq.size(), 0);
    results();
  end
endmodule : testbench
